/* File: design/wdw_prescale.v */
// prescaler and power-of-two postscaler counters
`timescale 1ns/1ps
`include "wdw_regs.vh"
module wdw_prescale #(
    parameter POST_W = 15
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        tick_i,
    input  wire        clear_i,
    input  wire        presel_i,
    input  wire [3:0]  post_i,
    output reg         expire_o,
    output wire        early_o,
    output wire [15:0] count_o
);
    reg  [6:0]        pre;
    reg  [POST_W-1:0] post;
    wire [6:0]        pre_top;
    wire [POST_W-1:0] post_top;
    wire [POST_W-1:0] quarter;
    assign pre_top  = presel_i ? `WDW_PRE_LONG : `WDW_PRE_SHORT;
    assign post_top = (({{(POST_W-1){1'b0}}, 1'b1} << post_i) - 1'b1);
    // first three quarters of the full period, counted in postscaler steps; zero when post_i is below 2
    assign quarter  = (post_i >= 4'h2) ? (post_top - (post_top >> 2)) : {POST_W{1'b0}};
    assign early_o  = (post < quarter);
    assign count_o  = {1'b0, post};
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre      <= 7'h00;
            post     <= {POST_W{1'b0}};
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (clear_i) begin
                pre  <= 7'h00;
                post <= {POST_W{1'b0}};
            end else if (tick_i) begin
                if (pre >= pre_top) begin
                    pre <= 7'h00;
                    if (post >= post_top) begin
                        post     <= {POST_W{1'b0}};
                        expire_o <= 1'b1;
                    end else begin
                        post <= post + 1'b1;
                    end
                end else begin
                    pre <= pre + 1'b1;
                end
            end
        end
    end
endmodule

/* File: design/wdw_regs.vh */
// constants and register map for the windowed watchdog
`ifndef WDW_REGS_VH
`define WDW_REGS_VH
`define WDW_ADDR_CTRL     12'h000
`define WDW_ADDR_STATUS   12'h004
`define WDW_ADDR_CONFIG   12'h008
`define WDW_ADDR_CMD      12'h00C
`define WDW_ADDR_COUNT    12'h010
`define WDW_BIT_SLEEP     3
`define WDW_BIT_IDLE      2
`define WDW_BIT_TIMEOUT   4
`define WDW_BIT_SWEN      5
`define WDW_BIT_WINDOW_OFF 6
`define WDW_BIT_PRESEL    4
`define WDW_BIT_HWEN      7
`define WDW_POST_LSB      0
`define WDW_POST_MSB      3
`define WDW_CMD_CLEAR     0
`define WDW_CMD_SLEEP     1
`define WDW_CMD_IDLE      2
`define WDW_CMD_WAKE      3
`define WDW_CMD_SWITCH    4
`define WDW_PRE_SHORT     7'h1F
`define WDW_PRE_LONG      7'h7F
`define WDW_RC_CLOCK_HZ   32767
`define WDW_SYS_HZ        40000000
`define WDW_CONFIG_RESET  8'hFF
`endif

/* File: design/wdw_sync.v */
// two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module wdw_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire d_i,
    output reg  q_o
);
    reg meta;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* File: design/wdw_top.v */
// windowed watchdog with apb registers
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wdw_regs.vh"
module wdw_top (
    input  wire        CLK_SYS_I,
    input  wire        SYS_RST_I,
    input  wire        LOW_POWER_RC_CLOCK_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    input  wire [3:0]  PSTRB_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    output reg         RC_OSC_EN_O,
    output reg         WDT_RESET_O,
    output reg         WAKE_O
);
    reg  [7:0]  config_word;
    reg         sw_enable;
    reg         timeout_flag;
    reg         sleep_bit;
    reg         idle_bit;
    reg         clear_pulse;
    reg         rc_clock_prev;
    reg         next_clear;
    wire        rc_clock_sync;
    wire        expire;
    wire        early;
    wire [15:0] count;
    wire        running;
    wire        powersave;
    wire        wr;
    wire        rd;
    wire [31:0] status_word;

    assign wr = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
    assign rd = PSEL_I & ~PWRITE_I & ~PENABLE_I;
    assign powersave = sleep_bit | idle_bit;
    assign running = config_word[`WDW_BIT_HWEN] | sw_enable;
    assign status_word = {26'h0, config_word[`WDW_BIT_HWEN] | sw_enable,
                          timeout_flag, sleep_bit, idle_bit, 2'h0};

    wdw_sync wdw_sync_i (
        .clk_i (CLK_SYS_I),
        .rst_i (SYS_RST_I),
        .d_i   (LOW_POWER_RC_CLOCK_I),
        .q_o   (rc_clock_sync)
    );

    wdw_prescale #(
        .POST_W (15)
    ) wdw_prescale_i (
        .clk_i    (CLK_SYS_I),
        .rst_i    (SYS_RST_I),
        .tick_i   (running & rc_clock_sync & ~rc_clock_prev),
        .clear_i  (clear_pulse | ~running),
        .presel_i (config_word[`WDW_BIT_PRESEL]),
        .post_i   (config_word[`WDW_POST_MSB:`WDW_POST_LSB]),
        .expire_o (expire),
        .early_o  (early),
        .count_o  (count)
    );

    // command decode: clear, sleep, idle, wake and switch all restart counts
    always @* begin
        next_clear = 1'b0;
        if (wr && PADDR_I == `WDW_ADDR_CMD && PSTRB_I[0]) begin
            next_clear = PWDATA_I[`WDW_CMD_CLEAR] | PWDATA_I[`WDW_CMD_SLEEP]
                       | PWDATA_I[`WDW_CMD_IDLE] | PWDATA_I[`WDW_CMD_WAKE]
                       | PWDATA_I[`WDW_CMD_SWITCH];
        end
        if (expire && powersave) begin
            next_clear = 1'b1;
        end
    end

    always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            config_word  <= `WDW_CONFIG_RESET;
            sw_enable    <= 1'b0;
            timeout_flag <= 1'b0;
            sleep_bit    <= 1'b0;
            idle_bit     <= 1'b0;
            clear_pulse  <= 1'b0;
            rc_clock_prev <= 1'b0;
            PRDATA_O     <= 32'h00000000;
            PREADY_O     <= 1'b0;
            PSLVERR_O    <= 1'b0;
            RC_OSC_EN_O  <= 1'b0;
            WDT_RESET_O  <= 1'b0;
            WAKE_O       <= 1'b0;
        end else begin
            rc_clock_prev <= rc_clock_sync;
            clear_pulse <= next_clear;
            RC_OSC_EN_O <= running;
            WDT_RESET_O <= 1'b0;
            WAKE_O      <= 1'b0;
            PREADY_O    <= PSEL_I & ~PENABLE_I;
            if (rd) begin
                case (PADDR_I)
                    `WDW_ADDR_CTRL:   PRDATA_O <= {24'h000000, config_word};
                    `WDW_ADDR_STATUS: PRDATA_O <= status_word;
                    `WDW_ADDR_CONFIG: PRDATA_O <= {24'h000000, config_word};
                    `WDW_ADDR_COUNT:  PRDATA_O <= {16'h0000, count};
                    default:          PRDATA_O <= 32'h00000000;
                endcase
            end
            PSLVERR_O <= PSEL_I & ~PENABLE_I & (PADDR_I != `WDW_ADDR_CTRL)
                       & (PADDR_I != `WDW_ADDR_STATUS) & (PADDR_I != `WDW_ADDR_CONFIG)
                       & (PADDR_I != `WDW_ADDR_CMD) & (PADDR_I != `WDW_ADDR_COUNT);
            if (wr && PSTRB_I[0]) begin
                if (PADDR_I == `WDW_ADDR_CONFIG) begin
                    config_word <= PWDATA_I[7:0];
                end
                if (PADDR_I == `WDW_ADDR_STATUS) begin
                    sw_enable    <= PWDATA_I[`WDW_BIT_SWEN];
                    timeout_flag <= PWDATA_I[`WDW_BIT_TIMEOUT];
                    sleep_bit    <= PWDATA_I[`WDW_BIT_SLEEP];
                    idle_bit     <= PWDATA_I[`WDW_BIT_IDLE];
                end
                if (PADDR_I == `WDW_ADDR_CMD) begin
                    if (PWDATA_I[`WDW_CMD_SLEEP]) begin
                        sleep_bit <= 1'b1;
                    end
                    if (PWDATA_I[`WDW_CMD_IDLE]) begin
                        idle_bit <= 1'b1;
                    end
                    if (PWDATA_I[`WDW_CMD_CLEAR] && running && !powersave
                        && !config_word[`WDW_BIT_WINDOW_OFF] && early) begin
                        WDT_RESET_O  <= 1'b1;
                        timeout_flag <= 1'b1;
                    end
                end
            end
            if (expire) begin
                timeout_flag <= 1'b1;
                if (powersave) begin
                    WAKE_O <= 1'b1;
                end else begin
                    WDT_RESET_O <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: tb/watchdog_timer_windowed_bench.sv */
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`include "wdw_regs.vh"
module watchdog_timer_windowed_bench;
    logic        clk = 0, rst = 1, rc_clk = 0, psel = 0, pen = 0, pwr = 0;
    logic [3:0]  stb = 4'hF;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd  = 32'h0, prd, rv;
    logic        rdy, err, osc, wrst, wake, e;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0, nr = 0, nw = 0, rb, wb, t, x, p;
    wdw_top wdw_top_i (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .LOW_POWER_RC_CLOCK_I(rc_clk), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(adr), .PWDATA_I(wd), .PSTRB_I(stb),
        .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err), .RC_OSC_EN_O(osc),
        .WDT_RESET_O(wrst), .WAKE_O(wake)
    );
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        rc_clk <= cyc[2];
        if (cyc == 60000) begin
            miscompares++;
            end_of_test;
        end
    end
    always @(negedge clk) begin
        nr += (wrst === 1'b1);
        nw += (wake === 1'b1);
    end
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] ex, logic [31:0] sn);
        checks++;
        if (sn !== ex) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", s, ex, sn);
        end
    endtask
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr  <= w;
        adr  <= a;
        wd   <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rv = prd;
        e  = err;
        psel <= 0;
        pen  <= 0;
    endtask
    task automatic evt(int lim);
        rb = nr;
        wb = nw;
        t  = 0;
        while (nr == rb && nw == wb && t < lim) begin
            @(negedge clk);
            t++;
        end
    endtask
    function automatic int tmo(logic ps, int po);
        return (ps ? 128 : 32) * (1 << po) * 8;
    endfunction
    task automatic near(string s);
        chk(s, x, (t > x - 24 && t < x + 24) ? x : t);
    endtask
    initial begin
        x = $urandom(89338);
        repeat (16) @(posedge clk);
        rst <= 0;
        bus(0, `WDW_ADDR_CTRL, 0);
        chk("config reset", 32'hFF, rv);
        bus(1, `WDW_ADDR_STATUS, 0);
        repeat (3) @(negedge clk);
        chk("osc held on", 1'b1, osc);
        bus(0, 12'h020, 0);
        chk("unmapped error", 1'b1, e);
        chk("unmapped data", 0, rv);
        for (int k = 0; k < 4; k++) begin
            p = $urandom_range(2);
            x = tmo(k[0], p);
            bus(1, `WDW_ADDR_CONFIG, 32'hC0 | (k[0] << 4) | p);
            bus(1, `WDW_ADDR_CMD, 32'h1);
            evt(x + 100);
            near("timeout cycles");
            chk("timeout reset", 1, nr - rb);
            bus(0, `WDW_ADDR_STATUS, 0);
            chk("timeout flag", 1'b1, rv[4]);
            bus(1, `WDW_ADDR_STATUS, 0);
        end
        bus(1, `WDW_ADDR_CONFIG, 32'hC1);
        rb = nr;
        for (int n = 0; n < 6; n++) begin
            bus(1, `WDW_ADDR_CMD, n[0] ? 32'h10 : 32'h1);
            repeat (300) @(posedge clk);
        end
        chk("kept alive", rb, nr);
        for (int k = 1; k < 3; k++) begin
            x = tmo(0, 1);
            repeat (150) @(posedge clk);
            bus(1, `WDW_ADDR_CMD, 1 << k);
            evt(x + 100);
            near("wake cycles");
            chk("wake pulse", 1, nw - wb);
            bus(0, `WDW_ADDR_STATUS, 0);
            chk("mode bit", 1'b1, rv[4 - k]);
            bus(1, `WDW_ADDR_STATUS, 0);
            bus(1, `WDW_ADDR_CMD, 32'h8);
        end
        bus(1, `WDW_ADDR_CONFIG, 32'h82);
        bus(1, `WDW_ADDR_CMD, 32'h1);
        repeat (880) @(posedge clk);
        rb = nr;
        bus(1, `WDW_ADDR_CMD, 32'h1);
        repeat (100) @(posedge clk);
        chk("late clear", rb, nr);
        bus(1, `WDW_ADDR_CMD, 32'h1);
        repeat (10) @(posedge clk);
        chk("early clear", rb + 1, nr);
        stb <= 4'hE;
        bus(1, `WDW_ADDR_CONFIG, 32'h00);
        stb <= 4'hF;
        bus(0, `WDW_ADDR_CONFIG, 0);
        chk("strobe masked", 32'h82, rv);
        bus(1, `WDW_ADDR_CONFIG, 32'h40);
        repeat (4) @(negedge clk);
        chk("osc off", 1'b0, osc);
        bus(1, `WDW_ADDR_STATUS, 32'h20);
        repeat (4) @(negedge clk);
        chk("osc on", 1'b1, osc);
        bus(1, `WDW_ADDR_CONFIG, 32'h4F);
        bus(1, `WDW_ADDR_CMD, 32'h1);
        repeat (400) @(posedge clk);
        bus(0, `WDW_ADDR_COUNT, 0);
        chk("count after clear", 1, rv);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        bus(0, `WDW_ADDR_COUNT, 0);
        chk("count after reset", 0, rv);
        bus(1, `WDW_ADDR_CONFIG, 32'h40);
        repeat (4) @(negedge clk);
        chk("swen after reset", 1'b0, osc);
        end_of_test;
    end
endmodule
bind wdw_top wdw_checker wdw_checker_i (
    .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .RC_OSC_EN_O(RC_OSC_EN_O), .WDT_RESET_O(WDT_RESET_O), .WAKE_O(WAKE_O)
);

/* File: tb/wdw_checker.sv */
// port checker for the windowed watchdog
`timescale 1ns/1ps
module wdw_checker (
    input logic        CLK_SYS_I,
    input logic        SYS_RST_I,
    input logic        PSEL_I,
    input logic        PENABLE_I,
    input logic        PWRITE_I,
    input logic [11:0] PADDR_I,
    input logic [31:0] PWDATA_I,
    input logic [3:0]  PSTRB_I,
    input logic [31:0] PRDATA_O,
    input logic        PREADY_O,
    input logic        PSLVERR_O,
    input logic        RC_OSC_EN_O,
    input logic        WDT_RESET_O,
    input logic        WAKE_O
);
    logic [7:0] cfg;
    wire        acc = PSEL_I && PENABLE_I;
    always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I)
            cfg <= 8'hFF;
        else if (acc && PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == 12'h008)
            cfg <= PWDATA_I[7:0];
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    rst_pulse_a: assert property (WDT_RESET_O |=> !WDT_RESET_O)
        else $error("reset request too long");
    wake_pulse_a: assert property (WAKE_O |=> !WAKE_O)
        else $error("wake too long");
    wake_excl_a: assert property (WAKE_O |-> !WDT_RESET_O)
        else $error("wake with reset");
    ready_acc_a: assert property ((PSEL_I && !PENABLE_I ##1 acc) |-> PREADY_O)
        else $error("no ready in access");
    ready_idle_a: assert property (!PSEL_I |-> !PREADY_O)
        else $error("ready while idle");
    bad_addr_a: assert property (acc && PADDR_I > 12'h010 |->
                                 PSLVERR_O && (PWRITE_I || PRDATA_O == 0))
        else $error("unmapped not refused");
    good_addr_a: assert property (acc && PADDR_I[1:0] == 0 && PADDR_I <= 12'h010 |-> !PSLVERR_O)
        else $error("mapped refused");
    cfg_read_a: assert property (acc && !PWRITE_I && PADDR_I == 0 |-> PRDATA_O[7:0] == cfg)
        else $error("config readback wrong");
    hw_on_a: assert property (cfg[7] [*4] |-> RC_OSC_EN_O)
        else $error("oscillator off");
    cover property (WAKE_O);
    cover property (WDT_RESET_O);
    cover property (acc && PSLVERR_O);
endmodule
